/* File: common/mac_pkg.sv */
package mac_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int OP_W = 16;
	localparam int PROD_W = 32;
	localparam int ACC_W = 40;
	localparam int ACC_LANES = 5;
	localparam int IRQ_W = 3;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_A_LOW = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_A_HIGH = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_B_LOW = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_B_HIGH = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_ACC0 = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_RND_LOW = 4'hb;
	localparam logic [ADDR_W-1:0] OFS_RND_HIGH = 4'hc;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'hd;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'he;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_MODE_BIT = 0;
	localparam int CFG_SAT_BIT = 1;
	localparam int CFG_CLR_BIT = 3;
	localparam int CFG_DIR_BIT = 4;
	localparam int CFG_SHIFT_BIT = 5;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_HOVF_BIT = 1;
	localparam int IRQ_SHIFT_BIT = 2;
	localparam int FLG_HOVF_BIT = 3;

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [3:0] FLAGS_RST = 4'h4;
	localparam logic [DATA_W-1:0] OVR_POS_TOP = 8'h7f;
	localparam logic [DATA_W-1:0] OVR_NEG_TOP = 8'h80;
	localparam logic [PROD_W-1:0] RND_HALF = 32'h0000_8000;
	localparam logic [OP_W-1:0] SAT_POS = 16'h7fff;
	localparam logic [OP_W-1:0] SAT_NEG = 16'h8000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic {
		MODE_MAC = 1'b0,
		MODE_MUL_ONLY = 1'b1
	} mode_e;

	typedef struct packed {
		logic hard_overflow_flag;
		logic zero;
		logic soft_overflow;
		logic negative;
	} flags_s;

	typedef struct packed {
		logic start;
		mode_e mode;
		logic signed [PROD_W-1:0] prod;
	} stage_s;

endpackage

/* File: src/mac_product_stage.sv */
`timescale 1ns/1ps

module mac_product_stage
	import mac_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_go,
	input wire mode_e i_mode,
	input wire logic [OP_W-1:0] i_a,
	input wire logic [OP_W-1:0] i_b,
	output stage_s o_stage
);

	// ----------------------------------------------------------------
	// First stage: signed product in one cycle
	// ----------------------------------------------------------------
	logic signed [PROD_W-1:0] prod_nxt;

	// Operands widened first so the product is formed at full width
	assign prod_nxt = $signed({{OP_W{i_a[OP_W-1]}}, i_a}) * $signed({{OP_W{i_b[OP_W-1]}}, i_b});

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_stage <= '0;
		end else if (i_ce) begin
			o_stage.start <= i_go;
			if (i_go) begin
				o_stage.mode <= i_mode;
				o_stage.prod <= prod_nxt;
			end
		end
	end

endmodule

/* File: src/mac_rounder.sv */
`timescale 1ns/1ps

module mac_rounder
	import mac_pkg::*;
(
	input wire logic [ACC_W-1:0] i_acc,
	input wire logic i_saturate,
	output logic [OP_W-1:0] o_round
);

	// ----------------------------------------------------------------
	// Round to nearest on bit 16, clamp to 16 bits when asked
	// ----------------------------------------------------------------
	logic [PROD_W-1:0] sum;
	logic wide;

	assign sum = i_acc[PROD_W-1:0] + RND_HALF;
	// Value no longer fits 32 signed bits
	assign wide = ~(&i_acc[ACC_W-1:PROD_W-1]) & (|i_acc[ACC_W-1:PROD_W-1]);

	always_comb begin
		o_round = sum[PROD_W-1:OP_W];
		if (i_saturate) begin
			if (wide) begin
				o_round = i_acc[ACC_W-1] ? SAT_NEG : SAT_POS;
			end else if (!i_acc[PROD_W-1] && sum[PROD_W-1]) begin
				o_round = SAT_POS;
			end
		end
	end

endmodule

/* File: src/multiply_accumulate_unit.sv */
`timescale 1ns/1ps

// Contract
// - Mode bit clear: signed 16x16 product added into the 40-bit accumulator.
// - Three pipeline stages, each exactly one clock.
// - Only a write to operand B low byte starts an operation.
// - Stage one multiplies; stage two adds and stores into the accumulator.
// - Flags update at the end of stage two from the new accumulator.
// - A new start during stage two is accepted and pipelined.
// - Rounded, optionally saturated result loads at the end of stage three.
// - Clear bit set at start clears accumulator and flags next clock, self-clears.
// - Mode bit set: product added to zero, overwriting the accumulator.
// - Multiply-only product visible two clocks after start, rounded after three.
// - Multiply-only operations leave the hard overflow flag unchanged.
// - Shift-start bit shifts accumulator one bit in one clock, then self-clears.
// - Shift-direction bit: zero shifts left, one shifts right.
// - Right shift is arithmetic, refilling bit 39 with itself.
// - Shifts never touch the status flags.
// - Hard overflow sets when overflow byte moves 0x7f to 0x80 or back.
// - Soft overflow sets on overflow into bit 31, clears once corrected.

module multiply_accumulate_unit
	import mac_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_irq
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic acc_lane_hit(input logic [ADDR_W-1:0] addr, input int lane);
		acc_lane_hit = (addr == OFS_ACC0 + ADDR_W'(lane));
	endfunction

	function automatic logic wr_hit(input logic we, input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs);
		wr_hit = we && (addr == ofs);
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic mode_sel_r;
	logic saturate_r;
	logic accumulator_clear_r;
	logic shift_direction_r;
	logic shift_start_r;
	logic [OP_W-1:0] operand_a_r;
	logic [OP_W-1:0] operand_b_r;
	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;
	logic [ACC_W-1:0] addend;
	logic [ACC_W-1:0] shifted;
	flags_s flags_r;
	logic [OP_W-1:0] round_r;
	logic [OP_W-1:0] round_nxt;
	logic start_go_r;
	logic clear_go_r;
	logic round_go_r;
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_events;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] read_mux;
	logic start_wr;
	logic cfg_wr;
	logic flags_wr;
	logic acc_wr;
	logic hovf_event;
	logic soft_ovf;
	logic [DATA_W-1:0] ovr_old;
	logic [DATA_W-1:0] ovr_new;
	logic acc_busy;
	stage_s stage1;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign start_wr = wr_hit(i_we, i_addr, OFS_B_LOW);
	assign cfg_wr = wr_hit(i_we, i_addr, OFS_CONFIG);
	assign flags_wr = wr_hit(i_we, i_addr, OFS_FLAGS);

	// Software may preload the accumulator one byte at a time
	always_comb begin
		acc_wr = 1'b0;
		for (int i = 0; i < ACC_LANES; i++) begin
			acc_wr = acc_wr | (i_we && acc_lane_hit(i_addr, i));
		end
	end

	// ----------------------------------------------------------------
	// Configuration
	// ----------------------------------------------------------------
	// Self-clears come first so that a software write in the same cycle wins
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mode_sel_r <= 1'b0;
			saturate_r <= 1'b0;
			accumulator_clear_r <= 1'b0;
			shift_direction_r <= 1'b0;
			shift_start_r <= 1'b0;
		end else if (i_ce) begin
			if (clear_go_r) begin
				accumulator_clear_r <= 1'b0;
			end
			if (shift_start_r) begin
				shift_start_r <= 1'b0;
			end
			if (cfg_wr) begin
				mode_sel_r <= i_wdata[CFG_MODE_BIT];
				saturate_r <= i_wdata[CFG_SAT_BIT];
				accumulator_clear_r <= i_wdata[CFG_CLR_BIT];
				shift_direction_r <= i_wdata[CFG_DIR_BIT];
				shift_start_r <= i_wdata[CFG_SHIFT_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Operands and start
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			operand_a_r <= '0;
			operand_b_r <= '0;
		end else if (i_ce) begin
			if (wr_hit(i_we, i_addr, OFS_A_LOW)) begin
				operand_a_r[DATA_W-1:0] <= i_wdata;
			end
			if (wr_hit(i_we, i_addr, OFS_A_HIGH)) begin
				operand_a_r[OP_W-1:DATA_W] <= i_wdata;
			end
			if (start_wr) begin
				operand_b_r[DATA_W-1:0] <= i_wdata;
			end
			if (wr_hit(i_we, i_addr, OFS_B_HIGH)) begin
				operand_b_r[OP_W-1:DATA_W] <= i_wdata;
			end
		end
	end

	// A start with the clear bit set runs a clear instead of a product
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			start_go_r <= 1'b0;
			clear_go_r <= 1'b0;
		end else if (i_ce) begin
			start_go_r <= start_wr && !accumulator_clear_r;
			clear_go_r <= start_wr && accumulator_clear_r;
		end
	end

	// ----------------------------------------------------------------
	// Stage one: product
	// ----------------------------------------------------------------
	mac_product_stage u_product (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_go(start_go_r),
		.i_mode(mode_e'(mode_sel_r)),
		.i_a(operand_a_r),
		.i_b(operand_b_r),
		.o_stage(stage1)
	);

	// ----------------------------------------------------------------
	// Stage two: accumulate
	// ----------------------------------------------------------------
	assign addend = (stage1.mode == MODE_MUL_ONLY) ? '0 : acc_r;
	assign acc_nxt = addend + {{(ACC_W-PROD_W){stage1.prod[PROD_W-1]}}, stage1.prod};

	assign ovr_old = acc_r[ACC_W-1:PROD_W];
	assign ovr_new = acc_nxt[ACC_W-1:PROD_W];
	assign hovf_event = stage1.start && (stage1.mode == MODE_MAC) &&
		(((ovr_old == OVR_POS_TOP) && (ovr_new == OVR_NEG_TOP)) ||
		((ovr_old == OVR_NEG_TOP) && (ovr_new == OVR_POS_TOP)));
	// Bits 39..31 disagree: sign bit 31 no longer holds the true sign
	assign soft_ovf = ~(&acc_nxt[ACC_W-1:PROD_W-1]) & (|acc_nxt[ACC_W-1:PROD_W-1]);

	always_comb begin
		if (shift_direction_r) begin
			shifted = {acc_r[ACC_W-1], acc_r[ACC_W-1:1]};
		end else begin
			shifted = {acc_r[ACC_W-2:0], 1'b0};
		end
	end

	// Shift that meets a stage-two add is dropped; the add owns the cycle
	assign acc_busy = clear_go_r || stage1.start;

	// A clear that meets a stage-two add wins; that product is lost
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			acc_r <= '0;
		end else if (i_ce) begin
			if (clear_go_r) begin
				acc_r <= '0;
			end else if (stage1.start) begin
				acc_r <= acc_nxt;
			end else if (shift_start_r) begin
				acc_r <= shifted;
			end else if (acc_wr) begin
				for (int i = 0; i < ACC_LANES; i++) begin
					if (acc_lane_hit(i_addr, i)) begin
						acc_r[DATA_W*i +: DATA_W] <= i_wdata;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Shifts are absent here on purpose
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			flags_r <= flags_s'(FLAGS_RST);
		end else if (i_ce) begin
			if (clear_go_r) begin
				flags_r <= '0;
			end else if (stage1.start) begin
				flags_r.zero <= (acc_nxt == '0);
				flags_r.negative <= acc_nxt[ACC_W-1];
				flags_r.soft_overflow <= soft_ovf;
				// Sticky: a software clear in this cycle loses to a new overflow
				flags_r.hard_overflow_flag <= hovf_event |
					(flags_wr ? i_wdata[FLG_HOVF_BIT] : flags_r.hard_overflow_flag);
			end else if (flags_wr) begin
				flags_r <= flags_s'(i_wdata[$bits(flags_s)-1:0]);
			end
		end
	end

	// ----------------------------------------------------------------
	// Stage three: rounding
	// ----------------------------------------------------------------
	mac_rounder u_rounder (
		.i_acc(acc_r),
		.i_saturate(saturate_r),
		.o_round(round_nxt)
	);

	// Round follows the accumulator by one clock after an add, shift or clear; byte writes to the accumulator do not load it
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			round_go_r <= 1'b0;
			round_r <= '0;
		end else if (i_ce) begin
			round_go_r <= stage1.start || (shift_start_r && !acc_busy) || clear_go_r;
			if (round_go_r) begin
				round_r <= round_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// Done fires at the end of stage two, together with the flags
	always_comb begin
		irq_events = '0;
		irq_events[IRQ_DONE_BIT] = stage1.start;
		irq_events[IRQ_HOVF_BIT] = hovf_event;
		irq_events[IRQ_SHIFT_BIT] = shift_start_r && !acc_busy;
	end

	// Write-one-to-clear; a new event in the clearing cycle stays set
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			irq_status_r <= '0;
			irq_mask_r <= '0;
		end else if (i_ce) begin
			if (wr_hit(i_we, i_addr, OFS_IRQ_STATUS)) begin
				irq_status_r <= (irq_status_r & ~i_wdata[IRQ_W-1:0]) | irq_events;
			end else begin
				irq_status_r <= irq_status_r | irq_events;
			end
			if (wr_hit(i_we, i_addr, OFS_IRQ_MASK)) begin
				irq_mask_r <= i_wdata[IRQ_W-1:0];
			end
		end
	end

	assign o_irq = |(irq_status_r & irq_mask_r);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Reads have no side effects, so polling never loses an event
	always_comb begin
		read_mux = '0;
		unique case (i_addr)
			OFS_CONFIG: begin
				read_mux[CFG_MODE_BIT] = mode_sel_r;
				read_mux[CFG_SAT_BIT] = saturate_r;
				read_mux[CFG_CLR_BIT] = accumulator_clear_r;
				read_mux[CFG_DIR_BIT] = shift_direction_r;
				read_mux[CFG_SHIFT_BIT] = shift_start_r;
			end
			OFS_FLAGS: read_mux = {4'h0, flags_r};
			OFS_A_LOW: read_mux = operand_a_r[DATA_W-1:0];
			OFS_A_HIGH: read_mux = operand_a_r[OP_W-1:DATA_W];
			OFS_B_LOW: read_mux = operand_b_r[DATA_W-1:0];
			OFS_B_HIGH: read_mux = operand_b_r[OP_W-1:DATA_W];
			OFS_RND_LOW: read_mux = round_r[DATA_W-1:0];
			OFS_RND_HIGH: read_mux = round_r[OP_W-1:DATA_W];
			OFS_IRQ_STATUS: read_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_status_r};
			OFS_IRQ_MASK: read_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
			default: begin
				for (int i = 0; i < ACC_LANES; i++) begin
					if (acc_lane_hit(i_addr, i)) begin
						read_mux = acc_r[DATA_W*i +: DATA_W];
					end
				end
			end
		endcase
	end

	// Data only in the cycle after the strobe, zero otherwise; the value holds while i_ce is low
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rdata_r <= '0;
		end else if (i_ce) begin
			rdata_r <= i_re ? read_mux : '0;
		end
	end

	assign o_rdata = rdata_r;

endmodule

/* File: verification/mac_checker_assertions.sv */
`timescale 1ns/1ps

module mac_checker
	import mac_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic o_irq
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] mask_r;
	logic start_d1_r;
	logic start_d2_r;
	wire logic start = i_ce && i_we && i_addr == OFS_B_LOW;
	wire logic cfg_wr = i_ce && i_we && i_addr == OFS_CONFIG;
	wire logic rd_ok = i_ce && i_re;
	wire logic irq_wr = i_we && (i_addr == OFS_IRQ_STATUS || i_addr == OFS_IRQ_MASK);
	wire logic acc_rd = rd_ok && (i_addr == OFS_FLAGS
		|| (i_addr >= OFS_ACC0 && i_addr <= OFS_ACC0 + 4'h4));

	// Mirror of the mask, so the interrupt can be judged from the ports
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mask_r <= '0;
		end else if (i_ce && i_we && i_addr == OFS_IRQ_MASK) begin
			mask_r <= i_wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			start_d1_r <= 1'b0;
			start_d2_r <= 1'b0;
		end else begin
			start_d1_r <= start;
			start_d2_r <= start_d1_r;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_RDATA_IDLE: assert property (!$past(i_re) && $past(i_ce) |-> o_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	AST_FLAGS_UNUSED: assert property (rd_ok && i_addr == OFS_FLAGS |=> o_rdata[7:4] == 4'h0)
		else $error("flags upper bits not zero");
	AST_CFG_UNUSED: assert property (rd_ok && i_addr == OFS_CONFIG
		|=> {o_rdata[7:6], o_rdata[2]} == 3'b000)
		else $error("config unused bits not zero");
	AST_UNMAPPED: assert property (rd_ok && i_addr == 4'hf |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_SHIFT_SELF_CLEAR: assert property (cfg_wr && i_wdata[CFG_SHIFT_BIT] ##1 (i_ce && !i_we)
		##1 (rd_ok && i_addr == OFS_CONFIG) |=> !o_rdata[CFG_SHIFT_BIT])
		else $error("shift start bit did not clear");
	AST_CLEAR_ZEROES: assert property (cfg_wr && i_wdata[CFG_CLR_BIT] ##1 !i_we ##1 start
		##1 (i_ce && !i_we) [*4] ##1 acc_rd |=> o_rdata == 8'h00)
		else $error("accumulator or flags not cleared");
	AST_IRQ_NEEDS_MASK: assert property (mask_r == '0 |-> !o_irq)
		else $error("interrupt while fully masked");
	AST_DONE_LATENCY: assert property (start && mask_r == 3'h1 && !o_irq && !start_d1_r
		&& !start_d2_r ##1 (i_ce && !irq_wr) ##1 (i_ce && !irq_wr) |-> !o_irq ##1 o_irq)
		else $error("operation done not at end of stage two");

	COV_OVERLAP: cover property (start ##2 start);
	COV_IRQ: cover property ($rose(o_irq));
	COV_SHIFT_RIGHT: cover property (cfg_wr && i_wdata[CFG_SHIFT_BIT] && i_wdata[CFG_DIR_BIT]);
endmodule

bind multiply_accumulate_unit mac_checker chk_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
	.o_irq(o_irq));

/* File: verification/core_model.sv */
`timescale 1ns/1ps

module core_model
	import mac_pkg::*;
(
	input wire logic i_mclk,
	input wire logic [DATA_W-1:0] i_rdata,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_wdata,
	output logic o_we,
	output logic o_re,
	output logic o_ce
);
	initial begin
		o_addr = '0;
		o_wdata = '0;
		o_we = 1'b0;
		o_re = 1'b0;
		o_ce = 1'b1;
	end

	// Starts are plain writes to operand B low; one may land in stage two
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_we <= 1'b1;
		@(posedge i_mclk);
		o_we <= 1'b0;
		// Idle bus shows a changed value, never the stale one
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_re <= 1'b1;
		@(posedge i_mclk);
		o_re <= 1'b0;
		o_addr <= ~a;
		@(negedge i_mclk);
		d = i_rdata;
	endtask
endmodule

/* File: verification/multiply_accumulate_unit_bench.sv */
`timescale 1ns/1ps

module multiply_accumulate_unit_bench;
	import mac_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic we;
	logic re;
	logic ce;
	logic irq;
	logic [DATA_W-1:0] rd_v;
	logic [ACC_W-1:0] acc_v;
	logic [ACC_W-1:0] acc_e = '0;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;

	always #12.5 mclk = ~mclk;

	core_model core_u (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_we(we), .o_re(re), .o_ce(ce));
	multiply_accumulate_unit dut_u (.i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_addr(addr),
		.i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata), .o_irq(irq));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [ACC_W-1:0] exp,
		input logic [ACC_W-1:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
		core_u.rd(a, rd_v);
		chk(what, 40'(exp), 40'(rd_v));
	endtask

	task automatic chk_irq(input logic exp);
		@(negedge mclk);
		chk("irq", 40'(exp), 40'(irq));
	endtask

	// Config goes last before the start so the mode is already in place
	task automatic op(input logic [15:0] a, input logic [15:0] b, input logic [7:0] cfg);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		core_u.wr(OFS_A_HIGH, a[15:8]);
		core_u.wr(OFS_A_LOW, a[7:0]);
		core_u.wr(OFS_B_HIGH, b[15:8]);
		core_u.wr(OFS_CONFIG, cfg);
		core_u.wr(OFS_B_LOW, b[7:0]);
		acc_e = cfg[CFG_CLR_BIT] ? '0 : (cfg[CFG_MODE_BIT] ? '0 : acc_e) + {{8{p[31]}}, p};
	endtask

	task automatic shift(input logic [7:0] cfg);
		core_u.wr(OFS_CONFIG, cfg);
		acc_e = cfg[CFG_DIR_BIT] ? {acc_e[39], acc_e[39:1]} : {acc_e[38:0], 1'b0};
	endtask

	// Pipeline needs three clocks before the round registers settle
	task automatic chk_acc();
		repeat (3) @(posedge mclk);
		for (int i = 0; i < ACC_LANES; i++) begin
			core_u.rd(OFS_ACC0 + 4'(i), rd_v);
			acc_v[8*i +: 8] = rd_v;
		end
		chk("accumulator", acc_e, acc_v);
	endtask

	task automatic chk_rnd(input logic [15:0] exp);
		rd(OFS_RND_HIGH, exp[15:8], "round high");
		rd(OFS_RND_LOW, exp[7:0], "round low");
	endtask

	// ----------------------------------------------------------------
	// Timeout and main sequence
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			finish_test();
		end
	end

	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rd(OFS_FLAGS, 8'(FLAGS_RST), "flags reset");
		rd(OFS_CONFIG, 8'h00, "config reset");
		chk_acc();
		core_u.wr(OFS_IRQ_MASK, 8'h01);
		op(16'h0003, 16'h0004, 8'h00);
		rd(OFS_FLAGS, 8'(FLAGS_RST), "flags in stage two");
		rd(OFS_FLAGS, 8'h00, "flags after stage two");
		chk_acc();
		chk_irq(1'b1);
		core_u.wr(OFS_IRQ_STATUS, 8'h01);
		chk_irq(1'b0);
		core_u.wr(OFS_IRQ_MASK, 8'h00);
		op(16'hfffe, 16'h0005, 8'h00);
		op(16'h0100, 16'h0100, 8'h00);
		core_u.wr(OFS_B_LOW, 8'h00);
		acc_e = acc_e + 40'h1_0000;
		chk_acc();
		rd(OFS_FLAGS, 8'h00, "flags after mac");
		op(16'h8000, 16'h8000, 8'h01);
		rd(OFS_ACC0 + 4'h3, 8'h00, "product in stage two");
		rd(OFS_RND_HIGH, 8'h40, "round after stage three");
		chk_acc();
		chk_rnd(16'h4000);
		repeat (9) shift(8'h21);
		chk_acc();
		rd(OFS_FLAGS, 8'h00, "flags after shift");
		shift(8'h31);
		rd(OFS_CONFIG, 8'h11, "config after shift");
		chk_acc();
		shift(8'h21);
		rd(OFS_IRQ_STATUS, 8'h05, "irq status after shift");
		core_u.wr(OFS_IRQ_STATUS, 8'h07);
		op(16'hffff, 16'h0001, 8'h02);
		chk_acc();
		rd(OFS_FLAGS, 8'h0a, "flags hard overflow");
		chk_rnd(SAT_POS);
		rd(OFS_IRQ_STATUS, 8'h03, "irq status");
		chk_irq(1'b0);
		core_u.wr(OFS_IRQ_MASK, 8'h02);
		chk_irq(1'b1);
		core_u.wr(OFS_IRQ_STATUS, 8'h02);
		chk_irq(1'b0);
		core_u.wr(OFS_IRQ_MASK, 8'h00);
		op(16'h0001, 16'h0001, 8'h01);
		chk_acc();
		rd(OFS_FLAGS, 8'h08, "flags multiply only");
		core_u.wr(OFS_FLAGS, 8'h00);
		rd(OFS_FLAGS, 8'h00, "flags written zero");
		op(16'h0002, 16'h0002, 8'h08);
		chk_acc();
		rd(OFS_FLAGS, 8'h00, "flags after clear");
		rd(OFS_CONFIG, 8'h00, "config after clear");
		core_u.wr(OFS_CONFIG, 8'hc6);
		rd(OFS_CONFIG, 8'h02, "config unused bits");
		rd(4'hf, 8'h00, "unmapped");
		finish_test();
	end
endmodule
